// ==== verilog/spi_flags_pkg.sv ====
package spi_flags_pkg;
	// Register location in the special function space
	localparam logic [7:0] CTRL_FLAGS_ADDR = 8'hf8;
	// Bit addresses of the bit-addressable register start here
	localparam logic [7:0] CTRL_BIT_BASE   = 8'hf8;
	// Field positions of spi_control_flags
	localparam int DONE_BIT     = 7;
	localparam int CLASH_BIT    = 6;
	localparam int CONFLICT_BIT = 5;
	localparam int OVERFLOW_BIT = 4;
	localparam int MODE_HI_BIT  = 3;
	localparam int MODE_LO_BIT  = 2;
	localparam int TXEMPTY_BIT  = 1;
	localparam int ENABLE_BIT   = 0;
	// Reset values of the mode and enable fields
	localparam logic [1:0] MODE_RESET   = 2'h1;
	localparam logic       ENABLE_RESET = 1'b0;
	// Mode code in which a low select pin means another master
	localparam logic [1:0] MODE_MULTI_MASTER = 2'h1;
	// Bits of one slave transfer, as a last-bit index
	localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
	localparam logic [2:0] BIT_COUNT_ZERO = 3'h0;
endpackage : spi_flags_pkg

// ==== verilog/pin_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module pin_sync
	import spi_flags_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// First stage is read only by the second
	always_comb begin
		nxt_meta = pin_in;
		nxt_sync = meta_ff;
	end

	// Reset high so an idle select pin reads inactive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign pin_sync_out = sync_ff;
endmodule : pin_sync

// ==== verilog/spi_control_flags.sv ====
`timescale 1ns/1ps
module spi_control_flags
	import spi_flags_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_bit_wr,
	input  wire logic       sfr_bit_val,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// Core status and control from the rest of the port
	input  wire logic       master_enable,
	input  wire logic       master_done,
	input  wire logic       master_busy,
	input  wire logic       data_write,
	input  wire logic       rx_unread,
	input  wire logic       transmit_buffer_empty,
	input  wire logic       spi_int_enable,
	// Bus pins
	input  wire logic       sck_pin,
	input  wire logic       select_pin,
	// Status and control outputs
	output logic            spi_irq,
	output logic      [1:0] select_pin_mode,
	output logic            port_enable,
	output logic            slave_last_bit
);
	logic [1:0] pins_sync;
	logic       sck_s;
	logic       sel_s;
	logic       sck_prev_ff, nxt_sck_prev;
	logic [2:0] bit_cnt_ff, nxt_bit_cnt;
	logic       last_bit_ff, nxt_last_bit;
	logic       done_ff, nxt_done;
	logic       clash_ff, nxt_clash;
	logic       conflict_ff, nxt_conflict;
	logic       overflow_ff, nxt_overflow;
	logic [1:0] mode_ff, nxt_mode;
	logic       enable_ff, nxt_enable;
	logic       irq_ff, nxt_irq;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [7:0] wmask;
	logic [7:0] wval;
	logic       busy;
	logic       slave_end;
	logic       conflict_cond;

	// Bit-addressed write selects one lane, byte write selects all
	function automatic logic [7:0] lane_mask(input logic [7:0] addr, input logic bit_wr,
		input logic byte_wr);
		logic [7:0] m;
		m = 8'h00;
		if (byte_wr && addr == CTRL_FLAGS_ADDR)
			m = 8'hff;
		else if (bit_wr && addr[7:3] == CTRL_BIT_BASE[7:3])
			m[addr[2:0]] = 1'b1;
		return m;
	endfunction : lane_mask

	// Select and serial clock cross into ref_clk here
	pin_sync #(.WIDTH(2)) u_sync (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.pin_in       ({sck_pin, select_pin}),
		.pin_sync_out (pins_sync)
	);
	assign sck_s = pins_sync[1];
	assign sel_s = pins_sync[0];

	// Write decode shared by all writable fields
	always_comb begin
		wmask = lane_mask(sfr_addr, sfr_bit_wr, sfr_wr);
		wval  = sfr_bit_wr ? {8{sfr_bit_val}} : sfr_wdata;
	end

	// Slave bit counter; counts sampling edges while selected
	always_comb begin
		nxt_sck_prev = sck_s;
		nxt_bit_cnt  = bit_cnt_ff;
		nxt_last_bit = 1'b0;
		if (master_enable || sel_s) begin
			nxt_bit_cnt = BIT_COUNT_ZERO;
		end else if (sck_s && !sck_prev_ff) begin
			nxt_bit_cnt  = bit_cnt_ff + 3'h1;
			nxt_last_bit = (bit_cnt_ff == LAST_BIT_INDEX);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sck_prev_ff <= 1'b1; // Same as synchroniser reset, no false edge
			bit_cnt_ff  <= BIT_COUNT_ZERO;
			last_bit_ff <= 1'b0;
		end else begin
			sck_prev_ff <= nxt_sck_prev;
			bit_cnt_ff  <= nxt_bit_cnt;
			last_bit_ff <= nxt_last_bit;
		end
	end

	// Slave transfer ends on the last sampled bit
	assign slave_end     = last_bit_ff;
	assign busy          = master_busy || (bit_cnt_ff != BIT_COUNT_ZERO);
	assign conflict_cond = !sel_s && master_enable && mode_ff == MODE_MULTI_MASTER;

	// Flags: hardware set wins over a software clear in the same cycle
	always_comb begin
		nxt_done     = wmask[DONE_BIT]     ? wval[DONE_BIT]     : done_ff;
		nxt_clash    = wmask[CLASH_BIT]    ? wval[CLASH_BIT]    : clash_ff;
		nxt_conflict = wmask[CONFLICT_BIT] ? wval[CONFLICT_BIT] : conflict_ff;
		nxt_overflow = wmask[OVERFLOW_BIT] ? wval[OVERFLOW_BIT] : overflow_ff;
		if (master_done || slave_end)
			nxt_done = 1'b1;
		if (data_write && busy)
			nxt_clash = 1'b1;
		if (conflict_cond)
			nxt_conflict = 1'b1;
		if (slave_end && rx_unread)
			nxt_overflow = 1'b1;
		nxt_mode = mode_ff;
		if (wmask[MODE_HI_BIT])
			nxt_mode[1] = wval[MODE_HI_BIT];
		if (wmask[MODE_LO_BIT])
			nxt_mode[0] = wval[MODE_LO_BIT];
		nxt_enable = wmask[ENABLE_BIT] ? wval[ENABLE_BIT] : enable_ff;
		// Request repeats while any flag stays set
		nxt_irq = spi_int_enable && (done_ff || clash_ff || conflict_ff || overflow_ff);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_ff     <= 1'b0;
			clash_ff    <= 1'b0;
			conflict_ff <= 1'b0;
			overflow_ff <= 1'b0;
			mode_ff     <= MODE_RESET;
			enable_ff   <= ENABLE_RESET;
			irq_ff      <= 1'b0;
		end else begin
			done_ff     <= nxt_done;
			clash_ff    <= nxt_clash;
			conflict_ff <= nxt_conflict;
			overflow_ff <= nxt_overflow;
			mode_ff     <= nxt_mode;
			enable_ff   <= nxt_enable;
			irq_ff      <= nxt_irq;
		end
	end

	// Read data registered; unmapped address reads zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (sfr_rd)
			nxt_rdata = (sfr_addr == CTRL_FLAGS_ADDR) ?
				{done_ff, clash_ff, conflict_ff, overflow_ff, mode_ff,
				 transmit_buffer_empty, enable_ff} : 8'h00;
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign sfr_rdata       = rdata_ff;
	assign spi_irq         = irq_ff;
	assign select_pin_mode = mode_ff;
	assign port_enable     = enable_ff;
	assign slave_last_bit  = last_bit_ff;

	done_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		master_done |=> done_ff)
		else $error("transfer done flag not set");
	done_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		done_ff && !wmask[DONE_BIT] |=> done_ff)
		else $error("transfer done flag cleared by hardware");
	irq_raise_a: assert property (@(posedge ref_clk) disable iff (rst)
		spi_int_enable && master_done |=> ##1 spi_irq)
		else $error("interrupt not raised after transfer");
	clash_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		data_write && master_busy |=> clash_ff ##1 (spi_irq || !$past(spi_int_enable)))
		else $error("write clash not flagged");
	conflict_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sel_s && master_enable && select_pin_mode == MODE_MULTI_MASTER |=> conflict_ff)
		else $error("master conflict not flagged");
	overflow_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		slave_last_bit && rx_unread |=> overflow_ff)
		else $error("receive overflow not flagged");
	slave_end_a: assert property (@(posedge ref_clk) disable iff (rst)
		slave_last_bit |-> $past(bit_cnt_ff) == LAST_BIT_INDEX)
		else $error("slave end not on last bit");
	mode_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		sfr_wr && !sfr_bit_wr && sfr_addr == CTRL_FLAGS_ADDR
		|=> select_pin_mode == $past(sfr_wdata[MODE_HI_BIT:MODE_LO_BIT]))
		else $error("select mode field not written");

	// Status flags hold until software writes their bit; slave end sets done; no request while disabled
	clash_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		clash_ff && !wmask[CLASH_BIT] |=> clash_ff)
		else $error("write clash flag cleared by hardware");
	conflict_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		conflict_ff && !wmask[CONFLICT_BIT] |=> conflict_ff)
		else $error("master conflict flag cleared by hardware");
	overflow_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		overflow_ff && !wmask[OVERFLOW_BIT] |=> overflow_ff)
		else $error("receive overflow flag cleared by hardware");
	slave_done_a: assert property (@(posedge ref_clk) disable iff (rst)
		slave_last_bit |=> done_ff)
		else $error("slave transfer end did not set done flag");
	irq_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		!spi_int_enable |=> !spi_irq)
		else $error("interrupt raised while disabled");
endmodule : spi_control_flags

// ==== verif/spi_master_model.sv ====
`timescale 1ns/1ps
// Far-side master: frames eight bits with a 160 ns clock
module spi_master_model (
	// Frame request
	input  wire logic go,
	// Bus pins and frame status
	output logic      sck_pin,
	output logic      select_pin,
	output logic      busy
);
	// Clock stands low and select rests high (pulled up) between frames
	initial begin
		sck_pin = 1'b0;
		select_pin = 1'b1;
		busy = 1'b0;
	end
	always @(posedge go) begin
		busy = 1'b1;
		select_pin = 1'b0;
		#100;
		repeat (8) begin
			#80 sck_pin = 1'b1;
			#80 sck_pin = 1'b0;
		end
		#100 select_pin = 1'b1;
		busy = 1'b0;
	end
endmodule : spi_master_model

// ==== verif/test_spi_control_flags.sv ====
`timescale 1ns/1ps
module test_spi_control_flags
	import spi_flags_pkg::*;
;
	logic       ref_clk, rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, go, busy;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic       master_enable, master_done, master_busy, data_write, rx_unread;
	logic       transmit_buffer_empty, spi_int_enable, sck_pin, select_pin;
	logic       spi_irq, port_enable, slave_last_bit;
	logic [1:0] select_pin_mode;
	int         fails, checks_done, n, pulses;
	spi_control_flags dut (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_val,
		.sfr_wdata, .sfr_rd, .sfr_rdata, .master_enable, .master_done, .master_busy,
		.data_write, .rx_unread, .transmit_buffer_empty, .spi_int_enable, .sck_pin,
		.select_pin, .spi_irq, .select_pin_mode, .port_enable, .slave_last_bit);
	spi_master_model partner (.go, .sck_pin, .select_pin, .busy);
	// Free-running system clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask : wr
	task automatic bwr(input logic [7:0] a, input logic v);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_bit_val <= v;
		sfr_bit_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_bit_wr <= 1'b0;
	endtask : bwr
	// Data is registered, so it is looked at just after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 chk(sfr_rdata, exp);
	endtask : rd
	// One frame; pulses sampled mid-cycle to stay clear of edge races
	task automatic frame;
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		pulses = 0;
		for (n = 0; n < 120; n++) begin
			@(negedge ref_clk);
			if (slave_last_bit === 1'b1) pulses++;
		end
		if (busy !== 1'b0) begin
			fails++;
			final_report;
		end
	endtask : frame
	task automatic final_report;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		{rst, transmit_buffer_empty, spi_int_enable} = 3'h7;
		{sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, go, master_enable} = 6'h00;
		{master_done, master_busy, data_write, rx_unread, sfr_addr, sfr_wdata} = 20'h0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(CTRL_FLAGS_ADDR, 8'h06);
		rd(8'h20, 8'h00);
		transmit_buffer_empty <= 1'b0;
		wr(CTRL_FLAGS_ADDR, 8'h0f);
		rd(CTRL_FLAGS_ADDR, 8'h0d);
		chk({4'h0, select_pin_mode, 1'b0, port_enable}, 8'h0d);
		wr(CTRL_FLAGS_ADDR, 8'h05);
		// Transfer end, then masking and bit clear of the request
		master_done <= 1'b1;
		@(posedge ref_clk);
		master_done <= 1'b0;
		repeat (20) @(posedge ref_clk);
		rd(CTRL_FLAGS_ADDR, 8'h85);
		chk({7'h0, spi_irq}, 8'h01);
		spi_int_enable <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({7'h0, spi_irq}, 8'h00);
		spi_int_enable <= 1'b1;
		bwr(CTRL_BIT_BASE + 8'h07, 1'b0);
		rd(CTRL_FLAGS_ADDR, 8'h05);
		chk({7'h0, spi_irq}, 8'h00);
		// Data write while the master is busy
		master_busy <= 1'b1;
		data_write <= 1'b1;
		@(posedge ref_clk);
		{master_busy, data_write} <= 2'h0;
		rd(CTRL_FLAGS_ADDR, 8'h45);
		wr(CTRL_FLAGS_ADDR, 8'h05);
		// Select low in master mode: mode 01 flags a conflict, mode 00 does not
		master_enable <= 1'b1;
		frame;
		rd(CTRL_FLAGS_ADDR, 8'h25);
		wr(CTRL_FLAGS_ADDR, 8'h01);
		frame;
		rd(CTRL_FLAGS_ADDR, 8'h01);
		master_enable <= 1'b0;
		wr(CTRL_FLAGS_ADDR, 8'h05);
		// Slave frames with and without unread receive data
		rx_unread <= 1'b1;
		frame;
		chk(pulses[7:0], 8'h01);
		rd(CTRL_FLAGS_ADDR, 8'h95);
		wr(CTRL_FLAGS_ADDR, 8'h05);
		rx_unread <= 1'b0;
		frame;
		rd(CTRL_FLAGS_ADDR, 8'h85);
		final_report;
	end
endmodule : test_spi_control_flags
